// ==== pkg/rcp_pkg.sv ====
// package: constants and types for the command repeat and presence block
package rcp_pkg;
    // result buffer geometry and tag identifier width
    localparam int unsigned BUF_DEPTH_DEF  = 246;
    localparam int unsigned BUF_BYTES      = 233;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned UID_W          = 64;
    // presence detection modes
    localparam logic [1:0]  PRES_MODE_OFF  = 2'h0;
    localparam logic [1:0]  PRES_MODE_SCAN = 2'h1;
    localparam logic [1:0]  PRES_MODE_RST  = 2'h1;
    // hysteresis filter length in clock cycles
    localparam int unsigned HYST_CYC_DEF   = 16;
    // sequencer states
    typedef enum logic [1:0]
    {
        RCP_IDLE = 2'b00,
        RCP_EXEC = 2'b01,
        RCP_WAIT = 2'b10
    } rcp_state_t;
endpackage

// ==== rtl/rcp_core.sv ====
// module: command repetition sequencer, result buffers and presence flag
////////////////////////////////////////////////////////////////////////////////
module rcp_core
#(
    parameter int unsigned BUF_DEPTH = rcp_pkg::BUF_DEPTH_DEF,
    parameter int unsigned HYST_CYC  = rcp_pkg::HYST_CYC_DEF
)
(
    // clock and reset
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_n_in,
    // host requests
    input  wire logic                       command_start_in,
    input  wire logic                       repeat_command_in,
    input  wire logic [7:0]                 command_code_in,
    input  wire logic [1:0]                 presence_detect_select_in,
    input  wire logic                       presence_select_load_in,
    // host status
    output logic                            module_working_out,
    output logic                            ready_out,
    output logic                            tag_in_field_flag_out,
    output logic                            presence_lamp_out,
    output logic                            field_on_out,
    output logic                            tag_error_out,
    output logic [7:0]                      stored_command_out,
    // radio side: tag seen and one result byte stream per tag
    input  wire logic                       tag_sense_in,
    input  wire logic                       tag_arrive_in,
    input  wire logic [rcp_pkg::UID_W-1:0]  tag_uid_in,
    input  wire logic                       tag_uid_valid_in,
    output logic                            exec_start_out,
    input  wire logic                       res_valid_in,
    input  wire logic [7:0]                 res_byte_in,
    input  wire logic                       res_last_in,
    // host result fetch
    output logic                            fetch_valid_out,
    output logic [7:0]                      fetch_byte_out,
    output logic                            fetch_last_out,
    input  wire logic                       fetch_ready_in,
    output logic [$clog2(BUF_DEPTH+1)-1:0]  buf_used_out
);
    localparam int unsigned PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int unsigned LW = $clog2(rcp_pkg::BUF_BYTES + 1);
    localparam int unsigned CW = $clog2(BUF_DEPTH + 1);
    localparam int unsigned HW = $clog2(HYST_CYC + 1);
    localparam int unsigned MW = $clog2(BUF_DEPTH * rcp_pkg::BUF_BYTES);

    // refuse sizes the slot pointers and length counters cannot serve
    if (BUF_DEPTH < 1 || BUF_DEPTH > 1024 || HYST_CYC < 1)
    begin : g_bad_params
        $error("rcp_core: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0]             res_mem [BUF_DEPTH * rcp_pkg::BUF_BYTES];
    logic [LW-1:0]          res_len [BUF_DEPTH];
    logic [PW-1:0]          wr_slot;
    logic [PW-1:0]          rd_slot;
    logic [LW-1:0]          wr_ofs;
    logic [LW-1:0]          rd_ofs;
    logic [CW-1:0]          used;
    rcp_pkg::rcp_state_t    state;
    logic                   cmd_loaded;
    logic                   last_uid_ok;
    logic [rcp_pkg::UID_W-1:0] last_uid;
    logic [1:0]             pres_mode;
    logic [HW-1:0]          hyst_cnt;
    logic                   pres;
    logic                   accept;
    logic                   uid_new;
    logic                   full;
    logic                   wr_done;
    logic                   rd_done;
    logic                   fetch_fire;

    assign full       = (used == CW'(BUF_DEPTH));
    assign uid_new    = !tag_uid_valid_in || !last_uid_ok
                        || (tag_uid_in != last_uid);
    // busy keeps a single-tag start open after the host drops repeat;
    // a finished single tag (ready up) blocks every tag until a new start
    assign accept     = (state == rcp_pkg::RCP_IDLE) && cmd_loaded && tag_arrive_in
                        && (repeat_command_in || module_working_out) && !ready_out
                        && !full && uid_new;
    assign wr_done    = (state == rcp_pkg::RCP_EXEC) && res_valid_in
                        && (res_last_in || wr_ofs == LW'(rcp_pkg::BUF_BYTES - 1));
    assign fetch_fire = fetch_valid_out && fetch_ready_in;
    assign rd_done    = fetch_fire && fetch_last_out;

    ////////////////////////////////////////////////////////////////////////////
    // command load on every start while idle, kept until the next one
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            cmd_loaded         <= 1'b0;
            stored_command_out <= 8'h00;
        end
        else if (command_start_in && state == rcp_pkg::RCP_IDLE)
        begin
            cmd_loaded         <= 1'b1;
            stored_command_out <= command_code_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: idle waits for a tag, exec collects one result
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            state       <= rcp_pkg::RCP_IDLE;
            ready_out   <= 1'b0;
        end
        else
        begin
            case (state)
                rcp_pkg::RCP_IDLE:
                begin
                    if (command_start_in)
                    begin
                        ready_out   <= 1'b0;
                    end
                    if (accept)
                    begin
                        state <= rcp_pkg::RCP_EXEC;
                    end
                end
                rcp_pkg::RCP_EXEC:
                begin
                    if (wr_done)
                    begin
                        state <= rcp_pkg::RCP_WAIT;
                    end
                end
                rcp_pkg::RCP_WAIT:
                begin
                    // repeat dropped: finish this one tag and stop
                    if (!repeat_command_in)
                    begin
                        ready_out   <= 1'b1;
                    end
                    state <= rcp_pkg::RCP_IDLE;
                end
                default:
                begin
                    state <= rcp_pkg::RCP_IDLE;
                end
            endcase
        end
    end

    // busy rises on a start with repeat or on accept, falls once a result is stored with repeat low
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            module_working_out <= 1'b0;
        end
        else if ((command_start_in && repeat_command_in) || accept)
        begin
            module_working_out <= 1'b1;
        end
        else if (state == rcp_pkg::RCP_WAIT && !repeat_command_in)
        begin
            module_working_out <= 1'b0;
        end
    end

    assign exec_start_out = accept;
    // a tag leaving mid-command is not a fault in any mode
    assign tag_error_out  = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // previous identifier memory
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            last_uid_ok <= 1'b0;
            last_uid    <= '0;
        end
        else if (accept && tag_uid_valid_in)
        begin
            last_uid_ok <= 1'b1;
            last_uid    <= tag_uid_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result buffer write side
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            wr_slot <= '0;
            wr_ofs  <= '0;
        end
        else if (state == rcp_pkg::RCP_EXEC && res_valid_in)
        begin
            res_mem[MW'(wr_slot) * MW'(rcp_pkg::BUF_BYTES) + MW'(wr_ofs)] <= res_byte_in;
            if (wr_done)
            begin
                res_len[wr_slot] <= LW'(wr_ofs + 1'b1);
                wr_ofs           <= '0;
                wr_slot          <= (wr_slot == PW'(BUF_DEPTH - 1)) ? '0 : PW'(wr_slot + 1'b1);
            end
            else
            begin
                wr_ofs <= LW'(wr_ofs + 1'b1);
            end
        end
    end

    // occupancy: fill and drain may meet in one cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            used <= '0;
        end
        else if (wr_done && !rd_done)
        begin
            used <= CW'(used + 1'b1);
        end
        else if (rd_done && !wr_done)
        begin
            used <= CW'(used - 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host fetch side, one registered byte per handshake
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rd_slot <= '0;
            rd_ofs  <= '0;
        end
        else if (fetch_fire)
        begin
            if (fetch_last_out)
            begin
                rd_ofs  <= '0;
                rd_slot <= (rd_slot == PW'(BUF_DEPTH - 1)) ? '0 : PW'(rd_slot + 1'b1);
            end
            else
            begin
                rd_ofs <= LW'(rd_ofs + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        fetch_byte_out <= res_mem[MW'(rd_slot) * MW'(rcp_pkg::BUF_BYTES) + MW'(rd_ofs)];
    end

    assign fetch_valid_out = (used != '0);
    assign fetch_last_out  = (LW'(rd_ofs + 1'b1) == res_len[rd_slot]);
    assign buf_used_out    = used;

    ////////////////////////////////////////////////////////////////////////////
    // presence mode select, enabled from reset
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            pres_mode <= rcp_pkg::PRES_MODE_RST;
        end
        else if (presence_select_load_in)
        begin
            pres_mode <= presence_detect_select_in;
        end
    end

    // hysteresis: sense must hold steady for the full count to flip
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            hyst_cnt <= '0;
            pres     <= 1'b0;
        end
        else if (tag_sense_in == pres)
        begin
            hyst_cnt <= '0;
        end
        else if (hyst_cnt == HW'(HYST_CYC - 1))
        begin
            hyst_cnt <= '0;
            pres     <= tag_sense_in;
        end
        else
        begin
            hyst_cnt <= HW'(hyst_cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            tag_in_field_flag_out <= 1'b0;
            presence_lamp_out     <= 1'b0;
            field_on_out          <= 1'b0;
        end
        else
        begin
            // only scan mode reports; mode 0 suppresses the flag
            tag_in_field_flag_out <= pres && pres_mode == rcp_pkg::PRES_MODE_SCAN;
            presence_lamp_out     <= pres && pres_mode == rcp_pkg::PRES_MODE_SCAN;
            field_on_out          <= (pres_mode == rcp_pkg::PRES_MODE_SCAN);
        end
    end
endmodule

// ==== bench/rcp_core_asserts.sv ====
// checker: port-level timing relations of the command repeat and presence block
module rcp_core_asserts
#(
    parameter int unsigned BUF_DEPTH = rcp_pkg::BUF_DEPTH_DEF,
    parameter int unsigned HYST_CYC  = rcp_pkg::HYST_CYC_DEF
)
(
    // clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_n_in,
    // host and radio side inputs
    input  wire logic                      command_start_in,
    input  wire logic                      repeat_command_in,
    input  wire logic                      tag_sense_in,
    // status outputs
    input  wire logic                      module_working_out,
    input  wire logic                      ready_out,
    input  wire logic                      tag_in_field_flag_out,
    input  wire logic                      presence_lamp_out,
    input  wire logic                      field_on_out,
    input  wire logic                      tag_error_out,
    input  wire logic [7:0]                stored_command_out,
    input  wire logic                      exec_start_out,
    input  wire logic [$clog2(BUF_DEPTH+1)-1:0] buf_used_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    // sense run lengths, saturating so a long idle never wraps to a short one
    always_ff @(posedge clk_sys_in)
    begin
        hi_cnt <= (!rst_n_in || !tag_sense_in) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
        lo_cnt <= (!rst_n_in || tag_sense_in) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_no_error;
        tag_error_out == 1'b0;
    endproperty
    a_no_error: assert property (p_no_error) else $error("error flag raised");
    property p_lamp;
        presence_lamp_out == tag_in_field_flag_out;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp differs from flag");
    property p_hyst;
        $rose(tag_in_field_flag_out) |-> hi_cnt >= HYST_CYC;
    endproperty
    a_hyst: assert property (p_hyst) else $error("flag rose without steady sense");
    property p_absent;
        lo_cnt > HYST_CYC + 2 |-> !tag_in_field_flag_out;
    endproperty
    a_absent: assert property (p_absent) else $error("flag held after tag left");
    property p_field;
        tag_in_field_flag_out |-> field_on_out;
    endproperty
    a_field: assert property (p_field) else $error("presence without field");
    property p_full;
        buf_used_out == BUF_DEPTH |-> !exec_start_out;
    endproperty
    a_full: assert property (p_full) else $error("tag taken while full");
    property p_exec_busy;
        exec_start_out |=> module_working_out;
    endproperty
    a_exec_busy: assert property (p_exec_busy) else $error("no busy after accept");
    property p_exec_rpt;
        ready_out |-> !exec_start_out;
    endproperty
    a_exec_rpt: assert property (p_exec_rpt) else $error("tag taken after single end");
    property p_ready;
        $rose(ready_out) |-> !module_working_out && $past(module_working_out);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without finished work");
    property p_cmd;
        $changed(stored_command_out) |-> $past(command_start_in);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command changed without start");
    // main scenarios reached
    c_full: cover property (buf_used_out == BUF_DEPTH);
    c_flag: cover property ($rose(tag_in_field_flag_out));
    c_ready: cover property ($rose(ready_out));
endmodule

bind rcp_core rcp_core_asserts #(.BUF_DEPTH(BUF_DEPTH), .HYST_CYC(HYST_CYC))
    rcp_core_asserts_inst (.*);

// ==== bench/rcp_tag_model.sv ====
// partner: radio-side tag that streams one result per accepted tag
module rcp_tag_model
#(
    parameter int unsigned NB = 3
)
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // block side
    input  wire logic       exec_start_in,
    output logic            res_valid_out,
    output logic [7:0]      res_byte_out,
    output logic            res_last_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       run;
    logic       idx_dummy_unused;
    logic [3:0] idx;
    logic [3:0] tag_n;
    assign idx_dummy_unused = 1'b0;
    // bytes {tag number, index}; idle byte lines toggle so stale data never matches
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            run           <= 1'b0;
            tag_n         <= 4'h0;
            res_valid_out <= 1'b0;
            res_last_out  <= 1'b0;
            res_byte_out  <= 8'h00;
        end
        else if (run)
        begin
            res_valid_out <= 1'b1;
            res_byte_out  <= {tag_n, idx};
            res_last_out  <= idx == 4'(NB - 1);
            idx           <= idx + 4'h1;
            run           <= idx != 4'(NB - 1);
            tag_n         <= tag_n + {3'h0, idx == 4'(NB - 1)};
        end
        else
        begin
            run           <= exec_start_in;
            idx           <= 4'h0;
            res_valid_out <= 1'b0;
            res_last_out  <= 1'b0;
            res_byte_out  <= ~res_byte_out;
        end
    end
endmodule

// ==== bench/tb_rfid_command_repeat_presence.sv ====
// testbench: presence, single-tag, repetition and result buffering
module tb_rfid_command_repeat_presence;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HYST = 8;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, command_start_in = 1'b0, repeat_command_in = 1'b0;
    logic presence_select_load_in = 1'b0, tag_sense_in = 1'b0, tag_arrive_in = 1'b0;
    logic tag_uid_valid_in = 1'b1, fetch_ready_in = 1'b0;
    logic [7:0] command_code_in = 8'h00;
    logic [1:0] presence_detect_select_in = 2'h1;
    logic [63:0] tag_uid_in = 64'h0000_0000_0000_0000;
    logic module_working_out, ready_out, tag_in_field_flag_out, presence_lamp_out, field_on_out;
    logic tag_error_out, exec_start_out, res_valid_in, res_last_in, fetch_valid_out, fetch_last_out;
    logic [7:0] stored_command_out, res_byte_in, fetch_byte_out;
    logic [1:0] buf_used_out;
    logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    // two buffers so the full case is reached in a few tags
    rcp_core #(.BUF_DEPTH(2), .HYST_CYC(HYST)) rcp_core_inst (.*);
    rcp_tag_model #(.NB(3)) rcp_tag_model_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .exec_start_in(exec_start_out),
        .res_valid_out(res_valid_in), .res_byte_out(res_byte_in), .res_last_out(res_last_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic arrive(input logic [63:0] u);
        tag_uid_in = u;
        tag_arrive_in = 1'b1;
        wt(1);
        tag_arrive_in = 1'b0;
    endtask
    // one byte per two cycles: fetched data lags the slot by a cycle
    task automatic fetch_buf(input logic [3:0] t);
        for (int w = 0; w < 100 && fetch_valid_out !== 1'b1; w++) wt(1);
        wt(1);
        for (int i = 0; i < 3; i++)
        begin
            chk(fetch_byte_out, {t, i[3:0]});
            chk({fetch_valid_out, fetch_last_out}, {1'b1, i == 2});
            fetch_ready_in = 1'b1;
            wt(1);
            fetch_ready_in = 1'b0;
            wt(1);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        wt(2);
        rst_n_in = 1'b1;
        wt(1);
        chk({field_on_out, tag_in_field_flag_out, module_working_out, buf_used_out}, 5'h10);
        tag_sense_in = 1'b1;
        wt(HYST + 4);
        chk({tag_in_field_flag_out, presence_lamp_out}, 2'h3);
        tag_sense_in = 1'b0;
        wt(HYST / 2);
        chk(tag_in_field_flag_out, 1'b1);
        wt(HYST + 2);
        chk(tag_in_field_flag_out, 1'b0);
        foreach (modes[k])
        begin
            presence_detect_select_in = modes[k];
            presence_select_load_in = 1'b1;
            wt(1);
            presence_select_load_in = 1'b0;
            tag_sense_in = 1'b1;
            wt(HYST + 4);
            chk({tag_in_field_flag_out, field_on_out}, {2{modes[k] == 2'h1}});
            tag_sense_in = 1'b0;
            wt(HYST + 4);
        end
        // single tag: start and repeat together, repeat dropped once busy
        command_code_in = 8'h02;
        command_start_in = 1'b1;
        repeat_command_in = 1'b1;
        wt(1);
        command_start_in = 1'b0;
        arrive(64'h0000_0000_0000_00a1);
        chk(module_working_out, 1'b1);
        repeat_command_in = 1'b0;
        for (int w = 0; w < 100 && ready_out !== 1'b1; w++) wt(1);
        chk({ready_out, module_working_out, stored_command_out, buf_used_out}, 12'h808 | 12'h001);
        // repeat raised again without a start must not wake the module
        repeat_command_in = 1'b1;
        arrive(64'h0000_0000_0000_00b2);
        wt(10);
        chk({ready_out, buf_used_out}, 3'h5);
        // continuous repetition: a fresh start, repeat stays high
        command_start_in = 1'b1;
        wt(1);
        command_start_in = 1'b0;
        command_code_in = 8'h03;
        arrive(64'h0000_0000_0000_00a1);
        wt(10);
        chk({ready_out, buf_used_out}, 3'h1);
        arrive(64'h0000_0000_0000_00b2);
        for (int w = 0; w < 50 && buf_used_out !== 2'h2; w++) wt(1);
        chk({stored_command_out, buf_used_out}, 10'h00a);
        tag_sense_in = 1'b0;
        // back in idle first, so only the full buffers can refuse the tag
        wt(2);
        arrive(64'h0000_0000_0000_00c3);
        wt(10);
        chk({buf_used_out, tag_error_out}, 3'h4);
        fetch_buf(4'h0);
        fetch_buf(4'h1);
        wt(2);
        chk(buf_used_out, 2'h0);
        arrive(64'h0000_0000_0000_00c3);
        for (int w = 0; w < 50 && buf_used_out !== 2'h1; w++) wt(1);
        chk(buf_used_out, 2'h1);
        // without an identifier the same tag counts as new
        tag_uid_valid_in = 1'b0;
        wt(2);
        arrive(64'h0000_0000_0000_00c3);
        for (int w = 0; w < 50 && buf_used_out !== 2'h2; w++) wt(1);
        chk(buf_used_out, 2'h2);
        repeat_command_in = 1'b0;
        wt(5);
        test_done();
    end
endmodule
